//--- bench/pio_bank_properties.sv
module pio_bank_properties (
    // clock and reset
    input wire logic               aclk,
    input wire logic               aresetn,
    // bus handshakes
    input wire logic               s_axi_awvalid,
    input wire logic               s_axi_awready,
    input wire logic               s_axi_wvalid,
    input wire logic               s_axi_wready,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic [31:0]        s_axi_rdata,
    input wire logic               s_axi_rvalid,
    input wire logic               s_axi_rready,
    // pads and power
    input wire pio_pkg::pad_ctrl_t pads,
    input wire logic               partial_powerdown_stop,
    input wire logic               partial_powerdown_wake
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    out_only_inbuf_a: assert property (!pads.in_buf_en[4]) else $error("output-only pin input on");
    in_only_drive_a: assert property (pads.oe_n[5]) else $error("input-only pin driven");
    pull_on_out_a: assert property ((pads.pull_en & ~pads.oe_n) == '0) else $error("pull on output");
    slew_on_in_a: assert property ((pads.slew_en & pads.oe_n) == '0) else $error("slew on input");
    drive_on_in_a: assert property ((pads.high_drive & pads.oe_n) == '0) else $error("drive on input");
    write_resp_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write response late");
    read_resp_lat_a: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
        else $error("read response late");
    read_data_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    stop_freeze_a: assert property (partial_powerdown_stop |=> ##1 $stable(pads)[*3]) else $error("pads moved");
    wake_freeze_a: assert property (partial_powerdown_wake |=> $stable(pads)[*2]) else $error("pads moved");
endmodule

bind pio_bank pio_bank_properties u_props (.*);

//--- bench/testbench.sv
`include "pio_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic               aclk = 0;
    logic               aresetn = 0;
    logic [11:0]        aa = '0;
    logic [11:0]        ra = '0;
    logic [31:0]        wd = '0;
    logic [31:0]        rdata;
    logic [31:0]        q;
    logic               awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, stp = 0, wk = 0;
    logic               awr, wry, arr, bv, rv;
    logic [1:0]         bresp, rresp, rs;
    logic [39:0]        pin = '0;
    logic [39:0]        pdin;
    pio_pkg::periph_t   pr = '0;
    pio_pkg::pad_ctrl_t pd, snap;
    int                 bad_count = 0;
    int                 compares = 0;

    pio_bank u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(aa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wry),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .pin_in(pin), .pads(pd), .periph(pr), .periph_din(pdin),
        .partial_powerdown_stop(stp), .partial_powerdown_wake(wk)
    );

    initial begin
        forever #12.5 aclk = ~aclk;
    end

    task wrap_up;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [39:0] s, input logic [39:0] e);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // address and data offered together, each released when taken
    task wr(input logic [11:0] a, input logic [31:0] d);
        bit da, dw;
        da = 0;
        dw = 0;
        @(posedge aclk);
        aa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        bre <= 1;
        while (!(da && dw)) begin
            @(posedge aclk);
            if (awr && !da) begin
                da = 1;
                awv <= 0;
            end
            if (wry && !dw) begin
                dw = 1;
                wv <= 0;
            end
        end
        do @(posedge aclk); while (!bv);
        rs = bresp;
        bre <= 0;
    endtask

    // rready raised late on purpose so the response has to stand
    task rd(input logic [11:0] a);
        @(posedge aclk);
        ra <= a;
        arv <= 1;
        do @(posedge aclk); while (!arr);
        arv <= 0;
        do @(posedge aclk); while (!rv);
        rre <= 1;
        @(posedge aclk);
        q = rdata;
        rs = rresp;
        rre <= 0;
    endtask

    task rc(input logic [11:0] a, input logic [39:0] e);
        rd(a);
        chk(q, e);
    endtask

    initial begin
        #(100us);
        bad_count++;
        wrap_up;
    end

    initial begin
        repeat (16) @(posedge aclk);
        chk(pd.oe_n, '1);
        aresetn <= 1;
        cyc(3);
        chk(pd.in_buf_en, ~`PIO_OUT_ONLY_MASK);
        for (int p = 0; p < 5; p++) begin
            rc(12'(p * 8 + 4), 40'h00_0000_0000);
            rc(12'(p * 16 + 'h100), 40'h00_0000_0000);
            rc(12'(p * 16 + 'h104), 40'h00_0000_00ff);
            rc(12'(p * 16 + 'h108), 40'h00_0000_0000);
        end
        wr(12'h008, 32'h0000_00a5);
        wr(12'h00c, 32'h0000_00ff);
        cyc(2);
        chk(pd.dout[15:8], 40'h00_0000_00a5);
        chk(pd.oe_n[15:8], 40'h00_0000_0000);
        pin[15:8] <= 8'h3c;
        cyc(8);
        rc(12'h008, 40'h00_0000_00a5);
        wr(12'h00c, 32'h0000_000f);
        rc(12'h008, 40'h00_0000_0035);
        wr(12'h000, 32'h0000_0010);
        pin[7:0] <= 8'h20;
        cyc(8);
        rc(12'h000, 40'h00_0000_0030);
        wr(12'h004, 32'h0000_00ff);
        rc(12'h000, 40'h00_0000_0030);
        pr.dig_en[23:16] <= 8'hff;
        pr.dig_oe[23:16] <= 8'hff;
        pr.dig_out[23:16] <= 8'h5a;
        pin[23:16] <= 8'hc3;
        wr(12'h120, 32'h0000_00ff);
        cyc(8);
        chk(pd.oe_n[23:16], 40'h00_0000_0000);
        chk(pd.dout[23:16], 40'h00_0000_005a);
        chk(pd.pull_en[23:16], 40'h00_0000_0000);
        chk(pdin[23:16], 40'h00_0000_00c3);
        chk(pdin[4], 40'h00_0000_0000);
        rc(12'h010, 40'h00_0000_00c3);
        rc(12'h120, 40'h00_0000_00ff);
        pr.analog_en[23:16] <= 8'hff;
        cyc(8);
        chk(pd.oe_n[23:16], 40'h00_0000_00ff);
        chk(pd.in_buf_en[23:16], 40'h00_0000_0000);
        chk(pdin[23:16], 40'h00_0000_0000);
        rc(12'h010, 40'h00_0000_0000);
        wr(12'h130, 32'h0000_00ff);
        wr(12'h138, 32'h0000_00ff);
        cyc(2);
        chk(pd.pull_en[31:24], 40'h00_0000_00ff);
        chk(pd.slew_en[31:24], 40'h00_0000_0000);
        chk(pd.high_drive[31:24], 40'h00_0000_0000);
        wr(12'h01c, 32'h0000_00ff);
        cyc(2);
        chk(pd.slew_en[31:24], 40'h00_0000_00ff);
        chk(pd.high_drive[31:24], 40'h00_0000_00ff);
        chk(pd.pull_en[31:24], 40'h00_0000_0000);
        wr(12'h028, 32'h0000_0001);
        chk(rs, `AXI_RESP_SLVERR);
        rd(12'h0fc);
        chk(rs, `AXI_RESP_SLVERR);
        pr <= '0;
        cyc(4);
        snap = pd;
        stp <= 1;
        @(posedge aclk);
        stp <= 0;
        pr.dig_en <= '1;
        cyc(5);
        chk(pd.oe_n, snap.oe_n);
        chk(pd.dout, snap.dout);
        pr <= '0;
        wk <= 1;
        @(posedge aclk);
        wk <= 0;
        cyc(3);
        rc(12'h180, 40'h00_0000_0001);
        chk(pd.dout, snap.dout);
        chk(pd.oe_n, snap.oe_n);
        wr(12'h180, 32'h0000_0002);
        cyc(3);
        chk(pd.oe_n, '1);
        rc(12'h180, 40'h00_0000_0000);
        wrap_up;
    end
endmodule

//--- core/axil_reg_slave.sv
module axil_reg_slave #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // write address and data
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // write response
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // read address and data
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // register side
    output logic                   wr_en,
    output logic [ADDR_W-1:0]      wr_addr,
    output logic [31:0]            wr_data,
    output logic [3:0]             wr_strb,
    input  wire logic              wr_err,
    output logic [ADDR_W-1:0]      rd_addr,
    input  wire logic [31:0]       rd_data,
    input  wire logic              rd_err
);

    logic aw_have_reg;
    logic w_have_reg;
    logic ar_have_reg;
    logic aw_take, w_take, ar_take;
    logic aw_have_next, w_have_next, bvalid_next, rvalid_next;

    assign aw_take      = awvalid & awready;
    assign w_take       = wvalid & wready;
    assign ar_take      = arvalid & arready;
    assign wr_en        = aw_have_reg & w_have_reg & ~bvalid;
    assign aw_have_next = (aw_have_reg | aw_take) & ~wr_en;
    assign w_have_next  = (w_have_reg | w_take) & ~wr_en;
    assign bvalid_next  = wr_en | (bvalid & ~bready);
    assign rvalid_next  = ar_have_reg | (rvalid & ~rready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            ar_have_reg <= 1'b0;
            awready     <= 1'b0;
            wready      <= 1'b0;
            arready     <= 1'b0;
            bvalid      <= 1'b0;
            bresp       <= `AXI_RESP_OKAY;
            rvalid      <= 1'b0;
            rresp       <= `AXI_RESP_OKAY;
            rdata       <= '0;
            wr_addr     <= '0;
            wr_data     <= '0;
            wr_strb     <= '0;
            rd_addr     <= '0;
        end else begin
            aw_have_reg <= aw_have_next;
            w_have_reg  <= w_have_next;
            ar_have_reg <= ar_take;
            // ready drops while an item is held or a response waits
            awready     <= ~aw_have_next & ~bvalid_next;
            wready      <= ~w_have_next & ~bvalid_next;
            arready     <= ~ar_take & ~rvalid_next;
            bvalid      <= bvalid_next;
            rvalid      <= rvalid_next;
            if (aw_take) begin
                wr_addr <= awaddr;
            end
            if (w_take) begin
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (ar_take) begin
                rd_addr <= araddr;
            end
            if (wr_en) begin
                bresp <= wr_err ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
            end
            if (ar_have_reg) begin
                rdata <= rd_err ? '0 : rd_data;
                rresp <= rd_err ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
            end
        end
    end

endmodule

//--- core/pin_sync3.sv
module pin_sync3 #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // asynchronous pins in, filtered level out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] agree;

    // a change counts only once stages two and three match
    assign agree = ~(s2_reg ^ s3_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg   <= '0;
            s2_reg   <= '0;
            s3_reg   <= '0;
            sync_out <= '0;
        end else begin
            s1_reg   <= async_in;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            sync_out <= (s2_reg & agree) | (sync_out & ~agree);
        end
    end

endmodule

//--- core/pio_bank.sv
`include "pio_regs.svh"

module pio_bank (
    // clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // AXI4-Lite write address and data
    input  wire logic [`PIO_ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    // AXI4-Lite read
    input  wire logic [`PIO_ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    // pads
    input  wire logic [`PIO_NUM_PINS-1:0] pin_in,
    output pio_pkg::pad_ctrl_t            pads,
    // shared peripherals
    input  wire pio_pkg::periph_t         periph,
    output logic [`PIO_NUM_PINS-1:0]      periph_din,
    // power controller
    input  wire logic                     partial_powerdown_stop,
    input  wire logic                     partial_powerdown_wake
);

    localparam int NP = `PIO_NUM_PORTS;
    localparam int PW = `PIO_PORT_W;
    localparam int NPIN = `PIO_NUM_PINS;
    localparam int AW = `PIO_ADDR_W;

    // register-side bus
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [31:0]   wr_data;
    logic [3:0]    wr_strb;
    logic          wr_err;
    logic [AW-1:0] rd_addr;
    logic [31:0]   rd_data;
    logic          rd_err;

    axil_reg_slave #(
        .ADDR_W (AW)
    ) u_slave (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_err  (wr_err),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_err  (rd_err)
    );

    // pins come from outside the clock domain
    logic [NPIN-1:0] pin_sync;

    pin_sync3 #(
        .WIDTH (NPIN)
    ) u_pin_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // one-hot port match against a register family
    function automatic logic [NP-1:0] port_hit(
        input logic [AW-1:0] addr,
        input logic [AW-1:0] base,
        input logic [AW-1:0] stride
    );
        logic [NP-1:0] hit;
        hit = '0;
        for (int p = 0; p < NP; p++) begin
            hit[p] = (addr == AW'(base + AW'(p) * stride));
        end
        return hit;
    endfunction

    // port registers
    logic [PW-1:0] data_reg  [NP];
    logic [PW-1:0] dir_reg   [NP];
    logic [PW-1:0] pull_reg  [NP];
    logic [PW-1:0] slew_reg  [NP];
    logic [PW-1:0] drive_reg [NP];

    // power-mode status and control
    pio_pkg::pwr_state_t pwr_state_reg;
    logic                ppd_flag_reg;

    // write decode: data/direction on the zero page, pin controls high page
    wire [NP-1:0] wr_hit_data  = port_hit(wr_addr, `PIO_DATA_OFS, `PIO_LO_STRIDE);
    wire [NP-1:0] wr_hit_dir   = port_hit(wr_addr, `PIO_DIR_OFS, `PIO_LO_STRIDE);
    wire [NP-1:0] wr_hit_pull  = port_hit(wr_addr, `PIO_PULL_OFS, `PIO_HI_STRIDE);
    wire [NP-1:0] wr_hit_slew  = port_hit(wr_addr, `PIO_SLEW_OFS, `PIO_HI_STRIDE);
    wire [NP-1:0] wr_hit_drive = port_hit(wr_addr, `PIO_DRIVE_OFS, `PIO_HI_STRIDE);
    wire          wr_hit_pwr   = (wr_addr == `PIO_PWR_OFS);
    wire          wr_lane0     = wr_en & wr_strb[0];

    assign wr_err = ~(|{wr_hit_data, wr_hit_dir, wr_hit_pull, wr_hit_slew, wr_hit_drive, wr_hit_pwr});

    // read decode
    wire [NP-1:0] rd_hit_data  = port_hit(rd_addr, `PIO_DATA_OFS, `PIO_LO_STRIDE);
    wire [NP-1:0] rd_hit_dir   = port_hit(rd_addr, `PIO_DIR_OFS, `PIO_LO_STRIDE);
    wire [NP-1:0] rd_hit_pull  = port_hit(rd_addr, `PIO_PULL_OFS, `PIO_HI_STRIDE);
    wire [NP-1:0] rd_hit_slew  = port_hit(rd_addr, `PIO_SLEW_OFS, `PIO_HI_STRIDE);
    wire [NP-1:0] rd_hit_drive = port_hit(rd_addr, `PIO_DRIVE_OFS, `PIO_HI_STRIDE);
    wire          rd_hit_pwr   = (rd_addr == `PIO_PWR_OFS);

    assign rd_err = ~(|{rd_hit_data, rd_hit_dir, rd_hit_pull, rd_hit_slew, rd_hit_drive, rd_hit_pwr});

    // acknowledge only takes effect as a written one
    wire ack_wr = wr_lane0 & wr_hit_pwr & wr_data[`PIO_PARTIAL_POWERDOWN_ACK_BIT];
    wire stop_enter = (pwr_state_reg == pio_pkg::PWR_RUN) & partial_powerdown_stop;
    wire stop_wake  = (pwr_state_reg == pio_pkg::PWR_STOP) & partial_powerdown_wake;
    wire frozen     = (pwr_state_reg != pio_pkg::PWR_RUN);

    // register contents are lost in partial power-down; on wake they reload defaults
    wire reg_clear  = ~aresetn | stop_wake;

    // flatten the port arrays into pin vectors
    logic [NPIN-1:0] latch_all;
    logic [NPIN-1:0] dir_all;
    logic [NPIN-1:0] pull_all;
    logic [NPIN-1:0] slew_all;
    logic [NPIN-1:0] drive_all;

    for (genvar p = 0; p < NP; p++) begin : g_port
        assign latch_all[p*PW +: PW] = data_reg[p];
        assign dir_all[p*PW +: PW]   = dir_reg[p];
        assign pull_all[p*PW +: PW]  = pull_reg[p];
        assign slew_all[p*PW +: PW]  = slew_reg[p];
        assign drive_all[p*PW +: PW] = drive_reg[p];

        always_ff @(posedge aclk) begin
            if (reg_clear) begin
                data_reg[p]  <= `PIO_DATA_RST;
                dir_reg[p]   <= `PIO_DIR_RST;
                pull_reg[p]  <= `PIO_PULL_RST;
                slew_reg[p]  <= `PIO_SLEW_RST;
                drive_reg[p] <= `PIO_DRIVE_RST;
            end else if (wr_lane0) begin
                // every latch bit is written, whatever its direction
                if (wr_hit_data[p]) begin
                    data_reg[p] <= wr_data[PW-1:0];
                end
                if (wr_hit_dir[p]) begin
                    dir_reg[p] <= wr_data[PW-1:0];
                end
                // pin controls decoded apart from data/direction
                if (wr_hit_pull[p]) begin
                    pull_reg[p] <= wr_data[PW-1:0];
                end
                if (wr_hit_slew[p]) begin
                    slew_reg[p] <= wr_data[PW-1:0];
                end
                if (wr_hit_drive[p]) begin
                    drive_reg[p] <= wr_data[PW-1:0];
                end
            end
        end
    end

    // pin ownership: analog first, then digital peripheral, then the port
    wire [NPIN-1:0] analog   = periph.analog_en;
    wire [NPIN-1:0] dig_own  = periph.dig_en & ~analog;

    // the input-only pin ignores the direction bit
    wire [NPIN-1:0] dir_eff  = dir_all & ~`PIO_IN_ONLY_MASK;

    // output buffer: none for analog or the input-only pin, peripheral's choice, else direction
    wire [NPIN-1:0] oe_eff   = ~analog & ~`PIO_IN_ONLY_MASK &
                               ((dig_own & periph.dig_oe) | (~dig_own & dir_eff));

    // input buffer off for analog and the output-only pin
    wire [NPIN-1:0] in_buf   = ~analog & ~`PIO_OUT_ONLY_MASK;

    wire [NPIN-1:0] dout_eff = (dig_own & periph.dig_out) | (~dig_own & latch_all);

    // pull device off whenever the pin drives or analog owns it
    wire [NPIN-1:0] pull_eff = pull_all & ~oe_eff & ~analog & ~`PIO_OUT_ONLY_MASK;

    // slew and drive only matter while the pin drives
    wire [NPIN-1:0] slew_eff  = slew_all & oe_eff;
    wire [NPIN-1:0] drive_eff = drive_all & oe_eff;

    // read source: latch for outputs and the output-only pin, else gated pin
    wire [NPIN-1:0] rd_latch = dir_eff | `PIO_OUT_ONLY_MASK;
    wire [NPIN-1:0] rd_pins  = (rd_latch & latch_all) |
                               (~rd_latch & in_buf & pin_sync);

    // read word assembly; every source is an argument, else the assign
    // would never re-evaluate when a register changes
    function automatic logic [31:0] read_word(
        input logic [NP-1:0]   hit_data,
        input logic [NP-1:0]   hit_dir,
        input logic [NP-1:0]   hit_pull,
        input logic [NP-1:0]   hit_slew,
        input logic [NP-1:0]   hit_drive,
        input logic            hit_pwr,
        input logic [NPIN-1:0] pins,
        input logic [NPIN-1:0] dir,
        input logic [NPIN-1:0] pull,
        input logic [NPIN-1:0] slew,
        input logic [NPIN-1:0] drive,
        input logic            flag
    );
        logic [31:0] word;
        word = '0;
        for (int p = 0; p < NP; p++) begin
            if (hit_data[p]) begin
                word[PW-1:0] = pins[p*PW +: PW];
            end
            if (hit_dir[p]) begin
                word[PW-1:0] = dir[p*PW +: PW];
            end
            if (hit_pull[p]) begin
                word[PW-1:0] = pull[p*PW +: PW];
            end
            if (hit_slew[p]) begin
                word[PW-1:0] = slew[p*PW +: PW];
            end
            if (hit_drive[p]) begin
                word[PW-1:0] = drive[p*PW +: PW];
            end
        end
        if (hit_pwr) begin
            word[`PIO_PARTIAL_POWERDOWN_FLAG_BIT] = flag;
        end
        return word;
    endfunction

    assign rd_data = read_word(rd_hit_data, rd_hit_dir, rd_hit_pull, rd_hit_slew, rd_hit_drive, rd_hit_pwr,
                               rd_pins, dir_all, pull_all, slew_all, drive_all, ppd_flag_reg);

    // power-mode sequencing; shallow stop needs nothing here, the clock and
    // all state simply stay alive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwr_state_reg <= pio_pkg::PWR_RUN;
            ppd_flag_reg  <= 1'b0;
        end else begin
            unique case (pwr_state_reg)
                pio_pkg::PWR_RUN: begin
                    if (stop_enter) begin
                        pwr_state_reg <= pio_pkg::PWR_STOP;
                    end
                end
                pio_pkg::PWR_STOP: begin
                    if (stop_wake) begin
                        pwr_state_reg <= pio_pkg::PWR_WAKE;
                    end
                end
                pio_pkg::PWR_WAKE: begin
                    // pins released only by the acknowledge write
                    if (ack_wr) begin
                        pwr_state_reg <= pio_pkg::PWR_RUN;
                    end
                end
            endcase
            // set wins over a clear in the same cycle
            if (stop_wake) begin
                ppd_flag_reg <= 1'b1;
            end else if (ack_wr) begin
                ppd_flag_reg <= 1'b0;
            end
        end
    end

    // pad outputs; frozen pads keep their pre-stop drive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pads.dout       <= '0;
            pads.oe_n       <= '1;
            pads.pull_en    <= '0;
            pads.slew_en    <= '0;
            pads.high_drive <= '0;
            pads.in_buf_en  <= '0;
            periph_din      <= '0;
        end else begin
            if (!frozen) begin
                pads.dout       <= dout_eff;
                pads.oe_n       <= ~oe_eff;
                pads.pull_en    <= pull_eff;
                pads.slew_en    <= slew_eff;
                pads.high_drive <= drive_eff;
                pads.in_buf_en  <= in_buf;
            end
            // peripherals see the pin through the same input buffer
            periph_din <= pin_sync & in_buf;
        end
    end

    // forty pins in five ports of eight

endmodule

//--- include/pio_pkg.sv
`include "pio_regs.svh"

package pio_pkg;

    // pad-facing controls for all pins
    typedef struct packed {
        logic [`PIO_NUM_PINS-1:0] dout;
        logic [`PIO_NUM_PINS-1:0] oe_n;
        logic [`PIO_NUM_PINS-1:0] pull_en;
        logic [`PIO_NUM_PINS-1:0] slew_en;
        logic [`PIO_NUM_PINS-1:0] high_drive;
        logic [`PIO_NUM_PINS-1:0] in_buf_en;
    } pad_ctrl_t;

    // requests from the peripherals that share the pins
    typedef struct packed {
        logic [`PIO_NUM_PINS-1:0] dig_en;
        logic [`PIO_NUM_PINS-1:0] dig_oe;
        logic [`PIO_NUM_PINS-1:0] dig_out;
        logic [`PIO_NUM_PINS-1:0] analog_en;
    } periph_t;

    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_STOP,
        PWR_WAKE
    } pwr_state_t;

endpackage

//--- include/pio_regs.svh
`ifndef PIO_REGS_SVH
`define PIO_REGS_SVH

`define PIO_NUM_PORTS     5
`define PIO_PORT_W        8
`define PIO_NUM_PINS      40
`define PIO_ADDR_W        12

// zero page: data and direction
`define PIO_DATA_OFS      12'h000
`define PIO_DIR_OFS       12'h004
`define PIO_LO_STRIDE     12'h008
// high page: pin controls and power-mode register
`define PIO_PULL_OFS      12'h100
`define PIO_SLEW_OFS      12'h104
`define PIO_DRIVE_OFS     12'h108
`define PIO_HI_STRIDE     12'h010
`define PIO_PWR_OFS       12'h180

`define PIO_DATA_RST      8'h00
`define PIO_DIR_RST       8'h00
`define PIO_PULL_RST      8'h00
`define PIO_SLEW_RST      8'hFF
`define PIO_DRIVE_RST     8'h00

`define PIO_PARTIAL_POWERDOWN_FLAG_BIT      0
`define PIO_PARTIAL_POWERDOWN_ACK_BIT    1

`define PIO_OUT_ONLY_MASK 40'h00_0000_0010
`define PIO_IN_ONLY_MASK  40'h00_0000_0020

`define AXI_RESP_OKAY     2'h0
`define AXI_RESP_SLVERR   2'h2

`endif
